// file: shared/ledd_pkg.sv
// Constants shared by the LED digit RAM and decoder block.
// Assumes a 10 MHz system clock; all timing counts derive from it.
package ledd_pkg;

  // System clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Time one digit stays lit in a scan step.
  localparam int unsigned DIGIT_ON_NS = 320000;
  // Interdigit blanking time between two digits.
  localparam int unsigned BLANK_NS = 10000;
  // Cycle counts derived from the times above.
  localparam int unsigned DIGIT_ON_CYC = DIGIT_ON_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
  // Width of the scan oscillator counter.
  localparam int CNT_W = 12;

  // Control word field positions.
  localparam int CW_ADDR_LSB = 0;
  localparam int CW_BANK_BIT = 3;
  localparam int CW_RUN_BIT = 4;
  localparam int CW_DECODE_BIT = 5;
  localparam int CW_HEX_BIT = 6;
  localparam int CW_FOLLOW_BIT = 7;
  // Decimal point position in a data byte; low lights the point.
  localparam int DP_BIT = 7;

  // Control reset: running, decoded, hexadecimal, bank A, digit 1.
  localparam logic [7:0] CTRL_RESET = 8'h70;
  // RAM reset values: code zero, decimal points dark.
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic DP_RESET = 1'b1;

  // Encodings of the three-level select input.
  localparam logic [1:0] TRI_LOW = 2'b00;
  localparam logic [1:0] TRI_HIGH = 2'b11;

  // Segment fonts, bit order a,b,c,d,e,f,g from msb to lsb.
  localparam logic [6:0] HEX_FONT [16] = '{
    7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
    7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47};
  localparam logic [6:0] EXT_FONT [16] = '{
    7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
    7'h7f, 7'h7b, 7'h01, 7'h4f, 7'h37, 7'h0e, 7'h67, 7'h00};

  // One-hot scan states.
  typedef enum logic [2:0] {
    SCAN_OFF = 3'b001,
    SCAN_BLANK = 3'b010,
    SCAN_ON = 3'b100
  } ledd_scan_t;

endpackage

// file: shared/ledd_seg_if.sv
// Carries one digit's stored data to the character decoder and the
// resulting segment pattern back. Purely combinational signals.
`timescale 1ns/1ps
`default_nettype none
interface ledd_seg_if;
  logic [3:0] code; // Character code of the digit.
  logic hex_sel; // High selects the hexadecimal font.
  logic raw_sel; // High shows the raw byte instead.
  logic [7:0] raw_byte; // Whole stored byte of the digit.
  logic [7:0] seg; // Lit segments {dp,a,b,c,d,e,f,g}.
  modport src (output code, output hex_sel, output raw_sel, output raw_byte, input seg);
  modport dec (input code, input hex_sel, input raw_sel, input raw_byte, output seg);
endinterface
`default_nettype wire

// file: verilog/ledd_char_decoder.sv
// Seven-segment character decoder for one digit.
// Assumes the caller registers the result; this module is combinational.
`timescale 1ns/1ps
`default_nettype none
module ledd_char_decoder (
  ledd_seg_if.dec port
);

  // Choose between the two fonts or the raw segment byte.
  always_comb
  begin
    if (port.raw_sel)
    begin
      // Raw bits 7..0 are dp,a,b,c,e,g,f,d; the point is negative true.
      port.seg = {~port.raw_byte[ledd_pkg::DP_BIT], port.raw_byte[6], port.raw_byte[5],
                  port.raw_byte[4], port.raw_byte[0], port.raw_byte[3],
                  port.raw_byte[1], port.raw_byte[2]};
    end
    else if (port.hex_sel)
    begin
      // Hexadecimal font, point lit by a low bit 7.
      port.seg = {~port.raw_byte[ledd_pkg::DP_BIT], ledd_pkg::HEX_FONT[port.code]};
    end
    else
    begin
      // Extended digit font; code 15 is blank, so FF gives a dark digit.
      port.seg = {~port.raw_byte[ledd_pkg::DP_BIT], ledd_pkg::EXT_FONT[port.code]};
    end
  end

endmodule
`default_nettype wire

// file: verilog/ledd_digit_ram_decoder.sv
// Display RAM, write port, character decoding and scan for an
// eight-digit seven-segment LED driver.
// Assumes all inputs are synchronous to clk_i; the write strobe is
// sampled and acted on at its rising edge.
`timescale 1ns/1ps
`default_nettype none
module ledd_digit_ram_decoder #(
  parameter bit DIRECT_ADDR = 1'b0,
  parameter int unsigned DIGIT_ON_CYC = ledd_pkg::DIGIT_ON_CYC,
  parameter int unsigned BLANK_CYC = ledd_pkg::BLANK_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic write_n_i,
  input wire logic reg_select_i,
  input wire logic [7:0] data_i,
  input wire logic [2:0] digit_addr_i,
  input wire logic [1:0] tri_level_format_select_i,
  output logic [7:0] digit_o,
  output logic [7:0] seg_o,
  output logic shutdown_o
);

  localparam int CW = ledd_pkg::CNT_W;

  // The scan counter is 12 bits wide; longer steps cannot be served.
  generate
    if (DIGIT_ON_CYC < 1 || DIGIT_ON_CYC > 4095 || BLANK_CYC < 1 || BLANK_CYC > 4095)
    begin : g_bad_timing
      $error("scan step counts must lie between 1 and 4095");
    end
  endgenerate

  // Turns a digit index into its one-hot digit line.
  function automatic logic [7:0] ledd_onehot(input logic [2:0] idx);
    ledd_onehot = 8'h01 << idx;
  endfunction

  logic write_n_d_reg; // Strobe as sampled one cycle earlier.
  logic take; // Rising edge of the write strobe.
  logic ctrl_wr; // Control register write this cycle.
  logic data_wr; // Display RAM write this cycle.
  logic [2:0] wr_addr; // Digit being written.
  logic wr_raw; // Write stores a raw segment byte.
  logic wr_bank; // Bank written by a decoded write.

  // Control register fields.
  logic ctrl_run_reg;
  logic ctrl_decode_reg;
  logic ctrl_hex_reg;
  logic ctrl_bank_reg;
  logic [2:0] ctrl_addr_reg;
  logic ctrl_follow_reg; // Kept for the sequential update mode.

  // Display RAM: two nibble banks, a shared point and a raw flag per digit.
  logic [3:0] bank_a_mem [8];
  logic [3:0] bank_b_mem [8];
  logic [7:0] dp_mem;
  logic [7:0] raw_flag;

  // Effective settings after the variant is taken into account.
  logic eff_run;
  logic eff_hex;
  logic eff_bank;

  // Scan oscillator.
  ledd_pkg::ledd_scan_t state_reg;
  logic [CW-1:0] scan_cnt;
  logic [2:0] idx_reg;

  ledd_seg_if seg_bus ();

  // Track the strobe so a write acts once, on its rising edge.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      write_n_d_reg <= 1'b1;
    else
      write_n_d_reg <= write_n_i;
  end

  assign take = write_n_i & ~write_n_d_reg;
  // The direct variant has no control path at all.
  assign ctrl_wr = take & ~DIRECT_ADDR & reg_select_i;
  assign data_wr = take & (DIRECT_ADDR | ~reg_select_i);
  assign wr_addr = DIRECT_ADDR ? digit_addr_i : ctrl_addr_reg;
  assign wr_raw = ~DIRECT_ADDR & ~ctrl_decode_reg;
  assign wr_bank = ~DIRECT_ADDR & ctrl_bank_reg;

  // Control register; a control write never touches the display RAM.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_run_reg <= ledd_pkg::CTRL_RESET[ledd_pkg::CW_RUN_BIT];
      ctrl_decode_reg <= ledd_pkg::CTRL_RESET[ledd_pkg::CW_DECODE_BIT];
      ctrl_hex_reg <= ledd_pkg::CTRL_RESET[ledd_pkg::CW_HEX_BIT];
      ctrl_bank_reg <= ledd_pkg::CTRL_RESET[ledd_pkg::CW_BANK_BIT];
      ctrl_addr_reg <= ledd_pkg::CTRL_RESET[ledd_pkg::CW_ADDR_LSB +: 3];
      ctrl_follow_reg <= ledd_pkg::CTRL_RESET[ledd_pkg::CW_FOLLOW_BIT];
    end
    else if (ctrl_wr)
    begin
      // Format fields latch here and apply to every decoded digit at once.
      ctrl_run_reg <= data_i[ledd_pkg::CW_RUN_BIT];
      ctrl_decode_reg <= data_i[ledd_pkg::CW_DECODE_BIT];
      ctrl_hex_reg <= data_i[ledd_pkg::CW_HEX_BIT];
      ctrl_bank_reg <= data_i[ledd_pkg::CW_BANK_BIT];
      ctrl_addr_reg <= data_i[ledd_pkg::CW_ADDR_LSB +: 3];
      ctrl_follow_reg <= data_i[ledd_pkg::CW_FOLLOW_BIT];
    end
  end

  // One storage slice per digit; writes are accepted even in shutdown.
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_digit
      always_ff @(posedge clk_i)
      begin
        if (!reset_n_i)
        begin
          bank_a_mem[g] <= ledd_pkg::NIB_RESET;
          bank_b_mem[g] <= ledd_pkg::NIB_RESET;
          dp_mem[g] <= ledd_pkg::DP_RESET;
          raw_flag[g] <= 1'b0;
        end
        else if (data_wr && wr_addr == 3'(g))
        begin
          // The point bit is common to both banks.
          dp_mem[g] <= data_i[ledd_pkg::DP_BIT];
          raw_flag[g] <= wr_raw;
          if (wr_raw)
          begin
            // A raw byte spans both nibbles, so banking is not possible.
            bank_a_mem[g] <= data_i[3:0];
            bank_b_mem[g] <= {1'b0, data_i[6:4]};
          end
          else if (wr_bank)
          begin
            // Bits 4..6 are ignored in decoded formats.
            bank_b_mem[g] <= data_i[3:0];
          end
          else
          begin
            bank_a_mem[g] <= data_i[3:0];
          end
        end
      end
    end
  endgenerate

  // The direct variant takes font and shutdown from the three-level pin.
  always_comb
  begin
    if (DIRECT_ADDR)
    begin
      eff_run = (tri_level_format_select_i != ledd_pkg::TRI_LOW);
      eff_hex = (tri_level_format_select_i == ledd_pkg::TRI_HIGH);
      eff_bank = 1'b0;
    end
    else
    begin
      eff_run = ctrl_run_reg;
      eff_hex = ctrl_hex_reg;
      eff_bank = ctrl_bank_reg;
    end
  end

  // Feed the scanned digit to the decoder.
  assign seg_bus.code = eff_bank ? bank_b_mem[idx_reg] : bank_a_mem[idx_reg];
  assign seg_bus.hex_sel = eff_hex;
  assign seg_bus.raw_sel = raw_flag[idx_reg];
  assign seg_bus.raw_byte = {dp_mem[idx_reg], bank_b_mem[idx_reg][2:0], bank_a_mem[idx_reg]};

  ledd_char_decoder u_decoder (
    .port (seg_bus)
  );

  // Scan oscillator; in shutdown it holds still, as the clock would.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ledd_pkg::SCAN_BLANK;
      scan_cnt <= '0;
      idx_reg <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        ledd_pkg::SCAN_OFF:
        begin
          // Resume with a blanking gap so no stale segments flash.
          if (eff_run)
          begin
            state_reg <= ledd_pkg::SCAN_BLANK;
            scan_cnt <= '0;
          end
        end
        ledd_pkg::SCAN_BLANK:
        begin
          if (!eff_run)
            state_reg <= ledd_pkg::SCAN_OFF;
          else if (scan_cnt == CW'(BLANK_CYC - 1))
          begin
            state_reg <= ledd_pkg::SCAN_ON;
            scan_cnt <= '0;
          end
          else
            scan_cnt <= scan_cnt + CW'(1);
        end
        ledd_pkg::SCAN_ON:
        begin
          if (!eff_run)
            state_reg <= ledd_pkg::SCAN_OFF;
          else if (scan_cnt == CW'(DIGIT_ON_CYC - 1))
          begin
            state_reg <= ledd_pkg::SCAN_BLANK;
            scan_cnt <= '0;
            idx_reg <= idx_reg + 3'h1;
          end
          else
            scan_cnt <= scan_cnt + CW'(1);
        end
      endcase
    end
  end

  // Drivers; everything is dark in shutdown and during blanking.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      digit_o <= 8'h00;
      seg_o <= 8'h00;
      shutdown_o <= 1'b0;
    end
    else
    begin
      shutdown_o <= ~eff_run;
      if (eff_run && state_reg == ledd_pkg::SCAN_ON)
      begin
        digit_o <= ledd_onehot(idx_reg);
        seg_o <= seg_bus.seg;
      end
      else
      begin
        digit_o <= 8'h00;
        seg_o <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Shutdown must darken every driver by the next edge.
  a_shutdown_dark: assert property (!eff_run |=> digit_o == 8'h00 && seg_o == 8'h00)
    else $error("drivers lit during shutdown");
  // A stopped oscillator does not count.
  a_scan_frozen: assert property (state_reg == ledd_pkg::SCAN_OFF && !eff_run |=> $stable(scan_cnt))
    else $error("scan counter moved in shutdown");
  // Control fields follow the written word.
  // The data-follows flag is stored too, ready for the sequential update mode.
  a_ctrl_latch: assert property (ctrl_wr |=> ctrl_run_reg == $past(data_i[ledd_pkg::CW_RUN_BIT])
    && ctrl_decode_reg == $past(data_i[ledd_pkg::CW_DECODE_BIT])
    && ctrl_hex_reg == $past(data_i[ledd_pkg::CW_HEX_BIT])
    && ctrl_bank_reg == $past(data_i[ledd_pkg::CW_BANK_BIT])
    && ctrl_addr_reg == $past(data_i[ledd_pkg::CW_ADDR_LSB +: 3])
    && ctrl_follow_reg == $past(data_i[ledd_pkg::CW_FOLLOW_BIT]))
    else $error("control word not latched");
  // Decoded bank A write reaches the addressed digit.
  a_digit_store: assert property (data_wr && !wr_raw && !wr_bank
    |=> bank_a_mem[$past(wr_addr)] == $past(data_i[3:0]))
    else $error("digit data not stored");
  // Point written for either bank lands in the shared point store.
  a_dp_shared: assert property (data_wr |=> dp_mem[$past(wr_addr)] == $past(data_i[7]))
    else $error("decimal point not stored");
  // The raw flag records the format of the last write.
  a_raw_flag: assert property (data_wr |=> raw_flag[$past(wr_addr)] == $past(wr_raw))
    else $error("raw flag not updated");
  // At most one digit line is ever driven.
  a_one_digit: assert property ($onehot0(digit_o))
    else $error("more than one digit driven");
  // Low on the three-level input reports shutdown next cycle.
  a_tri_shut: assert property (DIRECT_ADDR && tri_level_format_select_i == ledd_pkg::TRI_LOW
    |=> shutdown_o)
    else $error("three-level low did not shut down");
  // A control-only write leaves a digit's data untouched.
  a_ctrl_only: assert property (ctrl_wr && !data_wr |=> $stable(bank_a_mem[0]) && $stable(bank_b_mem[0]))
    else $error("control write changed display data");

  c_raw_write: cover property (data_wr && wr_raw);
  c_bank_b_write: cover property (data_wr && wr_bank && !wr_raw);
  c_shutdown_entry: cover property (eff_run ##1 !eff_run);
  c_digit8_lit: cover property (digit_o == 8'h80);

endmodule
`default_nettype wire

// file: verification/ledd_host_model.sv
// Host-side write master that feeds the LED digit block.
// Assumes the block samples every line on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module ledd_host_model (
  input wire logic clk_i,
  output logic write_n_o,
  output logic reg_select_o,
  output logic [7:0] data_o,
  output logic [2:0] digit_addr_o
);
  // The strobe idles high so that the first write after reset is clean.
  initial
  begin
    write_n_o = 1'b1;
    reg_select_o = 1'b0;
    data_o = 8'h00;
    digit_addr_o = 3'h0;
  end

  // One write cycle: lines set with the strobe low, strobe raised, lines held
  // through the edge that takes them, then released to a pattern unlike the data.
  task automatic put(input logic rs, input logic [2:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    write_n_o <= 1'b0;
    reg_select_o <= rs;
    digit_addr_o <= addr;
    data_o <= data;
    @(posedge clk_i);
    write_n_o <= 1'b1;
    @(posedge clk_i);
    // Released lines must not look like the last value written.
    data_o <= ~data;
    digit_addr_o <= ~addr;
    reg_select_o <= ~rs;
  endtask
endmodule
`default_nettype wire

// file: verification/ledd_digit_ram_decoder_tb_top.sv
// Self-checking bench for both variants of the LED digit block.
// Assumes short scan parameters so that a full scan takes 80 cycles.
`timescale 1ns/1ps
`default_nettype none
module ledd_digit_ram_decoder_tb_top;
  localparam int unsigned ON_CYC = 8;
  localparam int unsigned BL_CYC = 2;
  localparam int TIME_LIMIT = 20000;
  logic clk_i = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] tri_sel = 2'b11;
  logic c_wr_n, c_rs, d_wr_n, d_rs, c_sd, d_sd;
  logic [7:0] c_data, d_data, c_digit, c_seg, d_digit, d_seg;
  logic [2:0] c_addr, d_addr;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  // Free-running 10 MHz clock.
  always #50 clk_i = ~clk_i;

  ledd_host_model c_host (.clk_i(clk_i), .write_n_o(c_wr_n), .reg_select_o(c_rs), .data_o(c_data),
    .digit_addr_o(c_addr));
  ledd_host_model d_host (.clk_i(clk_i), .write_n_o(d_wr_n), .reg_select_o(d_rs), .data_o(d_data),
    .digit_addr_o(d_addr));
  // Control-word variant.
  ledd_digit_ram_decoder #(.DIRECT_ADDR(1'b0), .DIGIT_ON_CYC(ON_CYC), .BLANK_CYC(BL_CYC)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n), .write_n_i(c_wr_n), .reg_select_i(c_rs), .data_i(c_data),
    .digit_addr_i(c_addr), .tri_level_format_select_i(tri_sel), .digit_o(c_digit), .seg_o(c_seg),
    .shutdown_o(c_sd));
  // Direct-addressed variant.
  ledd_digit_ram_decoder #(.DIRECT_ADDR(1'b1), .DIGIT_ON_CYC(ON_CYC), .BLANK_CYC(BL_CYC)) dut_direct_u (
    .clk_i(clk_i), .reset_n_i(reset_n), .write_n_i(d_wr_n), .reg_select_i(d_rs), .data_i(d_data),
    .digit_addr_i(d_addr), .tri_level_format_select_i(tri_sel), .digit_o(d_digit), .seg_o(d_seg),
    .shutdown_o(d_sd));

  // Expected patterns, segment order {dp,a,b,c,d,e,f,g}; the point lights on a low bit 7.
  function automatic logic [7:0] hex_seg(input logic [7:0] b);
    hex_seg = {~b[7], ledd_pkg::HEX_FONT[b[3:0]]};
  endfunction
  function automatic logic [7:0] ext_seg(input logic [7:0] b);
    ext_seg = {~b[7], ledd_pkg::EXT_FONT[b[3:0]]};
  endfunction
  // Raw byte order is dp,a,b,c,e,g,f,d from bit 7 down.
  function automatic logic [7:0] raw_seg(input logic [7:0] b);
    raw_seg = {~b[7], b[6], b[5], b[4], b[0], b[3], b[1], b[2]};
  endfunction
  // Data byte for digit d: codes 8..15, point lit on even digits.
  function automatic logic [7:0] data_of(input int d);
    data_of = 8'(d + 8) | ((d % 2) == 1 ? 8'h80 : 8'h00);
  endfunction

  task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits, bounded, for the start of a fresh lit slot of a digit, then samples it one cycle in.
  // Joining a slot already under way could land on its last lit cycle and see the blanking.
  task automatic seg_at(input bit direct, input int idx, input logic [7:0] exp);
    logic [7:0] onehot;
    onehot = 8'h01 << idx;
    for (int n = 0; n < 200; n++)
    begin
      @(posedge clk_i);
      #1;
      if ((direct ? d_digit : c_digit) !== onehot)
        break;
    end
    for (int n = 0; n < 200; n++)
    begin
      @(posedge clk_i);
      #1;
      if ((direct ? d_digit : c_digit) === onehot)
        break;
    end
    @(posedge clk_i);
    #1;
    compare("digit drive", onehot, direct ? d_digit : c_digit);
    compare("segments", exp, direct ? d_seg : c_seg);
  endtask

  // Over more than one whole scan nothing may light while shut down.
  task automatic dark(input bit direct);
    logic [7:0] seen;
    seen = 8'h00;
    repeat (2) @(posedge clk_i);
    repeat (100)
    begin
      @(posedge clk_i);
      #1;
      seen = seen | (direct ? (d_digit | d_seg) : (c_digit | c_seg));
    end
    compare("dark outputs", 8'h00, seen);
    compare("shutdown flag", 8'h01, {7'h00, direct ? d_sd : c_sd});
  endtask

  task automatic end_of_test();
    $display("Summary: %0d checks, %0d errors", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hang counts as a mismatch and goes to the closing report.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == TIME_LIMIT)
    begin
      num_errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_n <= 1'b1;
    // Every address gets its own byte, then all are read back through the scan.
    for (int d = 0; d < 8; d++)
    begin
      c_host.put(1'b1, 3'h0, 8'h70 | 8'(d));
      c_host.put(1'b0, 3'h0, data_of(d));
    end
    for (int d = 0; d < 8; d++)
      seg_at(1'b0, d, hex_seg(data_of(d)));
    // A control-only word switches the font of every decoded digit.
    c_host.put(1'b1, 3'h0, 8'h30);
    for (int d = 0; d < 8; d++)
      seg_at(1'b0, d, ext_seg(data_of(d)));
    // Bank B holds its own nibble while the point is shared.
    c_host.put(1'b1, 3'h0, 8'h78);
    seg_at(1'b0, 0, hex_seg(8'h00));
    c_host.put(1'b0, 3'h0, 8'h83);
    seg_at(1'b0, 0, hex_seg(8'h83));
    c_host.put(1'b1, 3'h0, 8'h70);
    seg_at(1'b0, 0, hex_seg(8'h88));
    // Raw digit beside decoded ones, then the two blanking recipes.
    c_host.put(1'b1, 3'h0, 8'h51);
    c_host.put(1'b0, 3'h0, 8'h5a);
    seg_at(1'b0, 1, raw_seg(8'h5a));
    seg_at(1'b0, 0, hex_seg(8'h88));
    c_host.put(1'b0, 3'h0, 8'h80);
    seg_at(1'b0, 1, 8'h00);
    c_host.put(1'b1, 3'h0, 8'h32);
    c_host.put(1'b0, 3'h0, 8'hff);
    seg_at(1'b0, 2, 8'h00);
    // Shutdown by control word; a write during it must survive.
    c_host.put(1'b1, 3'h0, 8'h63);
    dark(1'b0);
    c_host.put(1'b0, 3'h0, 8'h07);
    c_host.put(1'b1, 3'h0, 8'h73);
    seg_at(1'b0, 3, hex_seg(8'h07));
    // Direct variant: bits 4..6 are ignored, format follows the three-level pin.
    d_host.put(1'b0, 3'h5, 8'h0c);
    seg_at(1'b1, 5, hex_seg(8'h0c));
    d_host.put(1'b1, 3'h5, 8'hfc);
    seg_at(1'b1, 5, hex_seg(8'h8c));
    for (int t = 1; t < 3; t++)
    begin
      @(posedge clk_i);
      tri_sel <= 2'(t);
      seg_at(1'b1, 5, ext_seg(8'h8c));
    end
    @(posedge clk_i);
    tri_sel <= 2'b00;
    dark(1'b1);
    d_host.put(1'b0, 3'h6, 8'h03);
    @(posedge clk_i);
    tri_sel <= 2'b11;
    seg_at(1'b1, 6, hex_seg(8'h03));
    end_of_test();
  end
endmodule
`default_nettype wire
